// ### dmap_arb.v
// Fixed-priority one-hot arbiter, lowest index wins
`timescale 1ns/1ps
`default_nettype none
module dmap_arb #(
  parameter N = 3
) (
  input  wire         en,
  input  wire [N-1:0] req,
  output reg  [N-1:0] grant
);
  integer i;
  reg     found;

  always @* begin
    grant = {N{1'b0}};
    found = 1'b0;
    for (i = 0; i < N; i = i + 1) begin
      if (en && req[i] && !found) begin
        grant[i] = 1'b1;
        found    = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### dmap_consts.vh
// Constants for the display memory access port
`ifndef DMAP_CONSTS_VH
`define DMAP_CONSTS_VH

// Register window indices on the plain register port
`define DMAP_REG_CTRL     3'h0
`define DMAP_REG_BLOCK    3'h1
`define DMAP_REG_ROW      3'h2
`define DMAP_REG_COL      3'h3
`define DMAP_REG_DATA     3'h4
`define DMAP_REG_STAT     3'h5

// Field positions
`define DMAP_CTRL_CC_BIT  0
`define DMAP_CTRL_CLR_BIT 1
`define DMAP_STAT_BSY_BIT 0

// External data space windows
`define DMAP_AUX_LO       16'h0000
`define DMAP_AUX_HI       16'h07FF
`define DMAP_TXT_LO       16'h2000
`define DMAP_TXT_HI       16'h47FF
`define DMAP_CC_LO        16'h8000
`define DMAP_CC_HI        16'h84FF

// Storage sizes and fill
`define DMAP_AUX_WORDS    2048
`define DMAP_DISP_WORDS   10240
`define DMAP_DISP_LAST    14'h27FF
`define DMAP_BLK_LAST     10'h3FF
`define DMAP_NUM_BLOCKS   4'hA
`define DMAP_FILL         8'h20
`define DMAP_UNMAPPED     8'hFF

// Pointer limits
`define DMAP_COL_LAST     6'h27
`define DMAP_COL_SPLIT    6'h20
`define DMAP_ROW_LAST     5'h19
`define DMAP_ROW_LAST_COL 6'h17
`define DMAP_HI_SLOT      10'h3F8

`endif

// ### dmap_far.sv
// Far-side model: capture engine and display reader
`timescale 1ns/1ps
`default_nettype none
module dmap_far (
  input wire logic        clk,
  output logic        cap_req = 1'b0,
  output logic        cap_we = 1'b0,
  output logic [13:0] cap_addr = 14'h0000,
  output logic [7:0]  cap_wdata = 8'h00,
  input wire logic        cap_ack,
  input wire logic [7:0]  cap_rdata,
  output logic        disp_req = 1'b0,
  output logic [13:0] disp_addr = 14'h0000,
  input wire logic        disp_ack,
  input wire logic [7:0]  disp_rdata
);
  // Requests are held until acked; on release address and write data flip, cap_we keeps value
  task automatic cap_write(input logic [13:0] a, input logic [7:0] d);
    cap_req <= 1'b1;
    cap_we <= 1'b1;
    cap_addr <= a;
    cap_wdata <= d;
    do @(posedge clk); while (cap_ack !== 1'b1);
    cap_req <= 1'b0;
    cap_addr <= ~a;
    cap_wdata <= ~d;
  endtask
  task automatic cap_read(input logic [13:0] a, output logic [7:0] d);
    cap_req <= 1'b1;
    cap_we <= 1'b0;
    cap_addr <= a;
    do @(posedge clk); while (cap_ack !== 1'b1);
    d = cap_rdata;
    cap_req <= 1'b0;
    cap_addr <= ~a;
  endtask
  task automatic disp_read(input logic [13:0] a, output logic [7:0] d);
    disp_req <= 1'b1;
    disp_addr <= a;
    do @(posedge clk); while (disp_ack !== 1'b1);
    d = disp_rdata;
    disp_req <= 1'b0;
    disp_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// ### dmap_properties.sv
// Port checker for the display memory access port
`timescale 1ns/1ps
`default_nettype none
module dmap_props (
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        XD_REQ,
  input wire logic        XD_WE,
  input wire logic [15:0] XD_ADDR,
  input wire logic        XD_ACK,
  input wire logic [7:0]  XD_RDATA,
  input wire logic        CAP_REQ,
  input wire logic        CAP_ACK,
  input wire logic        DISP_REQ,
  input wire logic        DISP_ACK,
  input wire logic        CLEAR_BUSY
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  sequence s_fill;
    CLEAR_BUSY [*8];
  endsequence
  sequence s_free;
    !XD_ACK && !CLEAR_BUSY && !DISP_REQ && !CAP_REQ && !REG_RD && !REG_WR;
  endsequence
  property p_fill;
    $fell(SRST) |-> s_fill;
  endproperty
  property p_quick;
    (XD_REQ and s_free) |=> XD_ACK;
  endproperty
  property p_prio;
    XD_ACK |-> $past((!DISP_REQ || DISP_ACK) && (!CAP_REQ || CAP_ACK));
  endproperty
  property p_quiet;
    CLEAR_BUSY && $past(CLEAR_BUSY) |-> !XD_ACK && !CAP_ACK && !DISP_ACK;
  endproperty
  property p_one;
    DISP_ACK |-> !XD_ACK && !CAP_ACK;
  endproperty
  property p_ack1;
    XD_ACK |=> !XD_ACK;
  endproperty
  property p_cause;
    $rose(XD_ACK) |-> $past(XD_REQ);
  endproperty
  property p_unmap;
    XD_ACK && !XD_WE && XD_ADDR[15:12] == 4'h1 |-> XD_RDATA == 8'hFF;
  endproperty
  property p_idle_rd;
    !$past(REG_RD) |-> REG_RDATA == 8'h00;
  endproperty
  a_fill: assert property (p_fill) else $error("fill too short");
  a_quick: assert property (p_quick) else $error("core not served");
  a_prio: assert property (p_prio) else $error("priority broken");
  a_quiet: assert property (p_quiet) else $error("ack in fill");
  a_one: assert property (p_one) else $error("two grants");
  a_ack1: assert property (p_ack1) else $error("ack too long");
  a_cause: assert property (p_cause) else $error("ack w/o req");
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  a_idle_rd: assert property (p_idle_rd) else $error("stray rdata");
endmodule
bind dmap_top dmap_props u_props (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .XD_REQ(XD_REQ), .XD_WE(XD_WE),
  .XD_ADDR(XD_ADDR), .XD_ACK(XD_ACK), .XD_RDATA(XD_RDATA),
  .CAP_REQ(CAP_REQ), .CAP_ACK(CAP_ACK), .DISP_REQ(DISP_REQ),
  .DISP_ACK(DISP_ACK), .CLEAR_BUSY(CLEAR_BUSY)
);
`default_nettype wire

// ### dmap_rowcol.v
// Row and column to block offset mapping and pointer advance
`timescale 1ns/1ps
`default_nettype none
`include "dmap_consts.vh"
module dmap_rowcol (
  input  wire [4:0] row,
  input  wire [5:0] col,
  output reg  [9:0] offset,
  output reg  [4:0] row_next,
  output reg  [5:0] col_next
);
  always @* begin
    // Columns past 31 fold into 8-byte slots stacked down from the top
    if (col < `DMAP_COL_SPLIT) begin
      offset = {row, col[4:0]};
    end else begin
      offset = `DMAP_HI_SLOT - {2'b00, row, 3'b000}
               + {7'h00, col[2:0]};
    end
  end

  always @* begin
    if (row == `DMAP_ROW_LAST && col == `DMAP_ROW_LAST_COL) begin
      row_next = 5'h00;
      col_next = 6'h00;
    end else if (col == `DMAP_COL_LAST) begin
      row_next = row + 5'h01;
      col_next = 6'h00;
    end else begin
      row_next = row;
      col_next = col + 6'h01;
    end
  end
endmodule
`default_nettype wire

// ### dmap_top.v
// Shared display and auxiliary memory access port
`timescale 1ns/1ps
`default_nettype none
`include "dmap_consts.vh"
module dmap_top (
  input  wire        SYS_CLK,
  input  wire        SRST,
  // Register port
  input  wire [2:0]  REG_ADDR,
  input  wire [7:0]  REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output wire [7:0]  REG_RDATA,
  // Core external data port
  input  wire        XD_REQ,
  input  wire        XD_WE,
  input  wire [15:0] XD_ADDR,
  input  wire [7:0]  XD_WDATA,
  output wire        XD_ACK,
  output wire [7:0]  XD_RDATA,
  // Data capture engine, physical display address
  input  wire        CAP_REQ,
  input  wire        CAP_WE,
  input  wire [13:0] CAP_ADDR,
  input  wire [7:0]  CAP_WDATA,
  output wire        CAP_ACK,
  output wire [7:0]  CAP_RDATA,
  // Display reader, physical display address
  input  wire        DISP_REQ,
  input  wire [13:0] DISP_ADDR,
  output wire        DISP_ACK,
  output wire [7:0]  DISP_RDATA,
  // Status
  output wire        CLEAR_BUSY
);
  // Storage: one display array aliased by both text windows
  reg  [7:0]  disp_mem [0:`DMAP_DISP_WORDS-1];
  reg  [7:0]  aux_mem  [0:`DMAP_AUX_WORDS-1];

  reg  [7:0]  dq_reg;
  reg  [7:0]  aq_reg;

  // Window and control state
  reg         cc_mode_reg;
  reg  [3:0]  blk_reg;
  reg  [4:0]  row_reg;
  reg  [5:0]  col_reg;
  reg  [7:0]  reg_rdata_reg;
  reg         rd_mem_reg;

  // Clear sequencer
  reg         clr_active_reg;
  reg  [13:0] clr_addr_reg;
  reg  [13:0] clr_end_reg;

  // Client answers
  reg         disp_ack_reg;
  reg         cap_ack_reg;
  reg         xd_ack_reg;
  reg  [1:0]  xd_src_reg;

  localparam SRC_DISP = 2'd0;
  localparam SRC_AUX  = 2'd1;
  localparam SRC_NONE = 2'd2;

  // Memory port selection
  reg         d_we;
  reg  [13:0] d_addr;
  reg  [7:0]  d_wd;
  reg         a_we;
  reg  [10:0] a_addr;

  wire [9:0]  rc_offset;
  wire [4:0]  row_next;
  wire [5:0]  col_next;
  wire [2:0]  grant;

  wire        blk_ok;
  wire        win_sel;
  wire        win_acc;
  wire [13:0] win_phys;
  wire        core_aux;
  wire        core_txt;
  wire        core_cc;
  wire [15:0] txt_off;
  wire [15:0] cc_off;
  wire [13:0] core_phys;
  wire [2:0]  req_vec;

  dmap_rowcol u_rowcol (
    .row      (row_reg),
    .col      (col_reg),
    .offset   (rc_offset),
    .row_next (row_next),
    .col_next (col_next)
  );

  assign blk_ok  = blk_reg < `DMAP_NUM_BLOCKS;
  assign win_sel = REG_ADDR == `DMAP_REG_DATA;
  // The window is a text-mode path and never waits, so it borrows a
  // single cycle ahead of the other clients
  assign win_acc = (REG_WR || REG_RD) && win_sel && !cc_mode_reg
                   && !clr_active_reg;
  // 1K blocks make the block base a plain concatenation
  assign win_phys = {blk_reg, rc_offset};

  assign core_aux = XD_ADDR <= `DMAP_AUX_HI;
  assign core_txt = !cc_mode_reg && XD_ADDR >= `DMAP_TXT_LO
                    && XD_ADDR <= `DMAP_TXT_HI;
  assign core_cc  = cc_mode_reg && XD_ADDR >= `DMAP_CC_LO
                    && XD_ADDR <= `DMAP_CC_HI;
  assign txt_off  = XD_ADDR - `DMAP_TXT_LO;
  assign cc_off   = XD_ADDR - `DMAP_CC_LO;
  // Text moves land on the same byte as the register window
  assign core_phys = core_txt ? txt_off[13:0] : cc_off[13:0];

  // A client whose answer is out this cycle is not granted again
  assign req_vec = {XD_REQ && !xd_ack_reg,
                    CAP_REQ && !cap_ack_reg,
                    DISP_REQ && !disp_ack_reg};

  dmap_arb #(
    .N (3)
  ) u_arb (
    .en    (!clr_active_reg && !win_acc),
    .req   (req_vec),
    .grant (grant)
  );

  always @* begin
    d_we   = 1'b0;
    d_addr = 14'h0000;
    d_wd   = 8'h00;
    a_we   = 1'b0;
    a_addr = XD_ADDR[10:0];
    if (clr_active_reg) begin
      d_we   = 1'b1;
      d_addr = clr_addr_reg;
      d_wd   = `DMAP_FILL;
    end else if (win_acc) begin
      d_we   = REG_WR && blk_ok;
      d_addr = win_phys;
      d_wd   = REG_WDATA;
    end else if (grant[0]) begin
      d_addr = DISP_ADDR;
    end else if (grant[1]) begin
      d_we   = CAP_WE;
      d_addr = CAP_ADDR;
      d_wd   = CAP_WDATA;
    end else if (grant[2]) begin
      if (core_aux) begin
        a_we = XD_WE;
      end else if (core_txt || core_cc) begin
        d_we   = XD_WE;
        d_addr = core_phys;
        d_wd   = XD_WDATA;
      end
    end
  end

  // Arrays carry no reset: auxiliary contents are left as found
  always @(posedge SYS_CLK) begin
    if (d_we) begin
      disp_mem[d_addr] <= d_wd;
    end
    if (a_we) begin
      aux_mem[a_addr] <= XD_WDATA;
    end
    dq_reg <= disp_mem[d_addr];
    aq_reg <= aux_mem[a_addr];
  end

  // Clear sequencer: full refill after reset, one block on request
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      clr_active_reg <= 1'b1;
      clr_addr_reg   <= 14'h0000;
      clr_end_reg    <= `DMAP_DISP_LAST;
    end else if (clr_active_reg) begin
      if (clr_addr_reg == clr_end_reg) begin
        clr_active_reg <= 1'b0;
      end else begin
        clr_addr_reg <= clr_addr_reg + 14'h0001;
      end
    end else if (REG_WR && REG_ADDR == `DMAP_REG_CTRL
                 && REG_WDATA[`DMAP_CTRL_CLR_BIT] && blk_ok) begin
      clr_active_reg <= 1'b1;
      clr_addr_reg   <= {blk_reg, 10'h000};
      clr_end_reg    <= {blk_reg, `DMAP_BLK_LAST};
    end
  end

  // Register writes and pointer advance
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      cc_mode_reg <= 1'b0;
      blk_reg     <= 4'h0;
      row_reg     <= 5'h00;
      col_reg     <= 6'h00;
    end else if (win_acc) begin
      // Out-of-range pointers give an undefined walk; not guarded
      row_reg <= row_next;
      col_reg <= col_next;
    end else if (REG_WR) begin
      if (REG_ADDR == `DMAP_REG_CTRL) begin
        cc_mode_reg <= REG_WDATA[`DMAP_CTRL_CC_BIT];
      end else if (REG_ADDR == `DMAP_REG_BLOCK) begin
        blk_reg <= REG_WDATA[3:0];
      end else if (REG_ADDR == `DMAP_REG_ROW) begin
        row_reg <= REG_WDATA[4:0];
      end else if (REG_ADDR == `DMAP_REG_COL) begin
        col_reg <= REG_WDATA[5:0];
      end
    end
  end

  // Register reads, answered in the following cycle
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      reg_rdata_reg <= 8'h00;
      rd_mem_reg    <= 1'b0;
    end else begin
      rd_mem_reg    <= 1'b0;
      reg_rdata_reg <= 8'h00;
      if (REG_RD) begin
        if (REG_ADDR == `DMAP_REG_CTRL) begin
          reg_rdata_reg <= {7'h00, cc_mode_reg};
        end else if (REG_ADDR == `DMAP_REG_BLOCK) begin
          reg_rdata_reg <= {4'h0, blk_reg};
        end else if (REG_ADDR == `DMAP_REG_ROW) begin
          reg_rdata_reg <= {3'h0, row_reg};
        end else if (REG_ADDR == `DMAP_REG_COL) begin
          reg_rdata_reg <= {2'h0, col_reg};
        end else if (REG_ADDR == `DMAP_REG_DATA) begin
          rd_mem_reg <= win_acc && blk_ok;
        end else if (REG_ADDR == `DMAP_REG_STAT) begin
          reg_rdata_reg <= {7'h00, clr_active_reg};
        end
      end
    end
  end

  // Client answers: acknowledge and data one cycle after the grant
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      disp_ack_reg <= 1'b0;
      cap_ack_reg  <= 1'b0;
      xd_ack_reg   <= 1'b0;
      xd_src_reg   <= SRC_NONE;
    end else begin
      disp_ack_reg <= grant[0];
      cap_ack_reg  <= grant[1];
      xd_ack_reg   <= grant[2];
      if (grant[2]) begin
        if (core_aux) begin
          xd_src_reg <= SRC_AUX;
        end else if (core_txt || core_cc) begin
          xd_src_reg <= SRC_DISP;
        end else begin
          xd_src_reg <= SRC_NONE;
        end
      end
    end
  end

  assign DISP_ACK   = disp_ack_reg;
  assign DISP_RDATA = dq_reg;
  assign CAP_ACK    = cap_ack_reg;
  assign CAP_RDATA  = dq_reg;
  assign XD_ACK     = xd_ack_reg;
  assign XD_RDATA   = (xd_src_reg == SRC_AUX)  ? aq_reg :
                      (xd_src_reg == SRC_DISP) ? dq_reg :
                      `DMAP_UNMAPPED;
  assign REG_RDATA  = rd_mem_reg ? dq_reg : reg_rdata_reg;
  assign CLEAR_BUSY = clr_active_reg;

endmodule
`default_nettype wire

// ### tb_display_memory_access_port.sv
// Self-checking bench for the display memory access port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_display_memory_access_port;
  logic        SYS_CLK = 1'b0;
  logic        SRST = 1'b1;
  logic [2:0]  REG_ADDR = 3'h0;
  logic [7:0]  REG_WDATA = 8'h00;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic        XD_REQ = 1'b0;
  logic        XD_WE = 1'b0;
  logic [15:0] XD_ADDR = 16'h0000;
  logic [7:0]  XD_WDATA = 8'h00;
  logic [7:0]  xq, rq, dq;
  int          fails = 0;
  int          compares = 0;
  wire [7:0]   REG_RDATA, XD_RDATA, CAP_WDATA, DISP_RDATA, CAP_RDATA;
  wire [13:0]  CAP_ADDR, DISP_ADDR;
  wire         XD_ACK, CAP_REQ, CAP_WE, CAP_ACK, DISP_REQ, DISP_ACK;
  wire         CLEAR_BUSY;
  always #4 SYS_CLK = ~SYS_CLK;
  dmap_top uut (.SYS_CLK(SYS_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .XD_REQ(XD_REQ), .XD_WE(XD_WE),
    .XD_ADDR(XD_ADDR), .XD_WDATA(XD_WDATA), .XD_ACK(XD_ACK),
    .XD_RDATA(XD_RDATA), .CAP_REQ(CAP_REQ), .CAP_WE(CAP_WE),
    .CAP_ADDR(CAP_ADDR), .CAP_WDATA(CAP_WDATA), .CAP_ACK(CAP_ACK),
    .CAP_RDATA(CAP_RDATA), .DISP_REQ(DISP_REQ), .DISP_ADDR(DISP_ADDR),
    .DISP_ACK(DISP_ACK), .DISP_RDATA(DISP_RDATA),
    .CLEAR_BUSY(CLEAR_BUSY));
  dmap_far u_far (.clk(SYS_CLK), .cap_req(CAP_REQ), .cap_we(CAP_WE),
    .cap_addr(CAP_ADDR), .cap_wdata(CAP_WDATA), .cap_ack(CAP_ACK),
    .disp_req(DISP_REQ), .disp_addr(DISP_ADDR), .disp_ack(DISP_ACK),
    .cap_rdata(CAP_RDATA), .disp_rdata(DISP_RDATA));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    @(posedge SYS_CLK);
    rq = REG_RDATA;
    `CHK(rq, e)
  endtask
  task automatic xd(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    XD_REQ <= 1'b1;
    XD_WE <= w;
    XD_ADDR <= a;
    XD_WDATA <= d;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (XD_ACK !== 1'b1 && n < 300);
    if (XD_ACK !== 1'b1) fails++;
    xq = XD_RDATA;
    XD_REQ <= 1'b0;
    XD_ADDR <= ~a;
    XD_WDATA <= ~d;
    @(posedge SYS_CLK);
  endtask
  task automatic xchk(input logic [15:0] a, input logic [7:0] e);
    xd(1'b0, a, 8'h00);
    `CHK(xq, e)
  endtask
  task automatic wait_fill;
    int n;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (CLEAR_BUSY !== 1'b0 && n < 12000);
    if (CLEAR_BUSY !== 1'b0) fails++;
  endtask
  task automatic print_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge SYS_CLK);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge SYS_CLK);
    SRST <= 1'b0;
    wait_fill();
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h26);
    rchk(3'h4, 8'h20);
    wr(3'h4, 8'hAA);
    wr(3'h4, 8'hBB);
    rchk(3'h3, 8'h01);
    rchk(3'h2, 8'h01);
    xchk(16'h23FF, 8'hAA);
    xchk(16'h2020, 8'hBB);
    wr(3'h2, 8'h19);
    wr(3'h3, 8'h17);
    wr(3'h4, 8'hCC);
    rchk(3'h2, 8'h00);
    rchk(3'h3, 8'h00);
    xchk(16'h2337, 8'hCC);
    xd(1'b1, 16'h2825, 8'h5A);
    wr(3'h1, 8'h02);
    wr(3'h2, 8'h01);
    wr(3'h3, 8'h05);
    rchk(3'h4, 8'h5A);
    xd(1'b1, 16'h07FF, 8'h77);
    xchk(16'h07FF, 8'h77);
    xchk(16'h1000, 8'hFF);
    wr(3'h0, 8'h01);
    rchk(3'h0, 8'h01);
    xchk(16'h83FF, 8'hAA);
    xchk(16'h23FE, 8'hFF);
    rchk(3'h4, 8'h00);
    wr(3'h0, 8'h00);
    u_far.cap_write(14'h0010, 8'h3C);
    xchk(16'h2010, 8'h3C);
    u_far.cap_read(14'h0010, dq);
    `CHK(dq, 8'h3C)
    fork
      u_far.disp_read(14'h03FF, dq);
      xd(1'b0, 16'h23FF, 8'h00);
    join
    `CHK(dq, 8'hAA)
    `CHK(xq, 8'hAA)
    wr(3'h0, 8'h02);
    rchk(3'h5, 8'h01);
    wait_fill();
    xchk(16'h2825, 8'h20);
    wr(3'h6, 8'hFF);
    rchk(3'h6, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
